// file: design/baud_prescaler.sv
// Fractional prescaler: divides source enables by ratio select plus one, plus spread inserts except in bypass (ratio select zero).
// Assumes src_en_i is a one-cycle enable synchronous to clk_sys_i.
`timescale 1ns/1ps
`include "sci_baud_consts.svh"
module baud_prescaler
  import sci_baud_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic src_en_i,
  input wire logic [2:0] prescale_ratio_select_i,
  input wire logic [4:0] clock_insertion_count_i,
  output logic out_en_o
);

  logic [3:0] cnt_r;
  logic [4:0] acc_r;
  logic [5:0] acc_sum;
  logic [3:0] limit;
  logic last;

  // Carry of the accumulator marks a stretched output cycle
  assign acc_sum = {1'b0, acc_r} + {1'b0, clock_insertion_count_i};
  assign limit = {1'b0, prescale_ratio_select_i} + {3'h0, acc_sum[5]};
  assign last = (cnt_r == limit);

  // Input clock counter
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cnt_r <= 4'h0;
    end else if (src_en_i) begin
      if (last || prescale_ratio_select_i == `RATIO_BYPASS) begin
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + `RATIO_COUNT_STEP;
      end
    end
  end

  // Accumulator spreads inserts evenly over 32 outputs
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      acc_r <= 5'h00;
    end else if (src_en_i && last && prescale_ratio_select_i != `RATIO_BYPASS) begin
      acc_r <= acc_sum[4:0];
    end
  end

  // Output pulse; bypass passes the source straight on
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      out_en_o <= 1'b0;
    end else if (prescale_ratio_select_i == `RATIO_BYPASS) begin
      out_en_o <= src_en_i;
    end else begin
      out_en_o <= src_en_i && last;
    end
  end

endmodule : baud_prescaler

// file: design/pulse_divider.sv
// Divides a one-cycle enable by a run-time divisor.
// Assumes the divisor is at least one and changes only while idle.
`timescale 1ns/1ps
module pulse_divider
  import sci_baud_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic en_i,
  input wire logic [12:0] divisor_i,
  output logic tick_o
);

  logic [12:0] cnt_r;

  // Counter and tick
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      cnt_r <= 13'h0000;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (en_i) begin
        if (cnt_r >= divisor_i - 13'h0001) begin
          cnt_r <= 13'h0000;
          tick_o <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 13'h0001;
        end
      end
    end
  end

endmodule : pulse_divider

// file: design/sci_baud_consts.svh
// Constants of the serial baud generator and data buffer block.
// Assumes inclusion by bare name; holds definitions only.
`ifndef SCI_BAUD_CONSTS_SVH
`define SCI_BAUD_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFF_DATA_BUFFER 8'h18
`define OFF_BAUD_RATE 8'h1C
`define OFF_PRESCALER 8'h20
`define OFF_STATUS 8'h24

// ****************************************************************
// Reset values and field masks
// ****************************************************************
`define BAUD_RATE_RESET 8'h00
`define PRESCALER_RESET 8'h00
`define BAUD_RATE_WMASK 8'hF7
`define TE_FLAG_RESET 1'b1
`define RF_FLAG_RESET 1'b0
`define STAT_TE_BIT 7
`define STAT_RF_BIT 5

// ****************************************************************
// Divisors
// ****************************************************************
`define PREDIV_CODE0 4'h1
`define PREDIV_CODE1 4'h3
`define PREDIV_CODE2 4'h4
`define PREDIV_CODE3 4'hD
`define BAUD_DIV_ONE 8'h01
`define RATIO_BYPASS 3'h0
`define RATIO_COUNT_STEP 4'h1
`define RT_DIVIDE 4'h4
`define RT_PER_BIT_LAST 4'hF

// ****************************************************************
// Break lengths in bit times
// ****************************************************************
`define BRK_NORMAL_8 4'hA
`define BRK_NORMAL_9 4'hB
`define BRK_LIN_LONG_8 4'hD
`define BRK_LIN_LONG_9 4'hE
`define BRK_LIN_SHORT_8 4'hB
`define BRK_LIN_SHORT_9 4'hC

`endif

// file: design/sci_baud_generator_lin_break.sv
// Serial data buffer, LIN break length control and baud rate generator.
// Assumes a classic Wishbone master, shift registers and a config bit outside.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "sci_baud_consts.svh"
module sci_baud_generator_lin_break
  import sci_baud_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Clock source
  input wire logic baud_source_select_i,
  input wire logic crystal_clock_en_i,
  // Character length, high for 9-bit characters
  input wire logic nine_bit_char_i,
  // Shift register side
  input wire logic tx_load_i,
  input wire logic rx_load_i,
  input wire logic [7:0] rx_byte_i,
  output logic [7:0] transmit_byte_o,
  output logic tx_buffer_empty_flag_o,
  output logic rx_buffer_full_flag_o,
  // Rate and break outputs
  output logic rt_tick_o,
  output logic bit_tick_o,
  output logic [3:0] rx_break_bits_o,
  output logic [3:0] tx_break_bits_o
);

  // ****************************************************************
  // Register storage
  // ****************************************************************
  baud_rate_control_s baud_rate_control_r;
  baud_prescaler_control_s baud_prescaler_control_r;
  logic [7:0] received_byte_r;
  logic [7:0] transmit_byte_r;
  logic te_r;
  logic rf_r;
  logic ack_r;
  logic [31:0] rdata_r;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic access;
  logic wr_low;
  logic [7:0] word_adr;
  logic hit_data;
  logic hit_baud;
  logic hit_psc;
  logic hit_stat;
  logic data_wr;
  logic data_rd;

  // Access qualifies once per bus cycle
  // Address bits 1:0 and byte lanes 3:1 are ignored; every register
  // sits in byte lane 0 of its word
  assign access = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_low = access && wb_we_i && wb_sel_i[0];
  assign word_adr = {wb_adr_i[7:2], 2'b00};

  // Address decoding
  always_comb begin
    hit_data = 1'b0;
    hit_baud = 1'b0;
    hit_psc = 1'b0;
    hit_stat = 1'b0;
    if (word_adr == `OFF_DATA_BUFFER) begin
      hit_data = 1'b1;
    end else if (word_adr == `OFF_BAUD_RATE) begin
      hit_baud = 1'b1;
    end else if (word_adr == `OFF_PRESCALER) begin
      hit_psc = 1'b1;
    end else if (word_adr == `OFF_STATUS) begin
      hit_stat = 1'b1;
    end
  end

  assign data_wr = wr_low && hit_data;
  assign data_rd = access && !wb_we_i && hit_data;

  // Acknowledge one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= access;
    end
  end

  // Read data mux; unmapped addresses read zero
  // Captured at the taken edge, so it stands with the acknowledge
  // and holds until the next read
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (access && !wb_we_i) begin
      if (hit_data) begin
        rdata_r <= {24'h000000, received_byte_r};
      end else if (hit_baud) begin
        rdata_r <= {24'h000000, baud_rate_control_r};
      end else if (hit_psc) begin
        rdata_r <= {24'h000000, baud_prescaler_control_r};
      end else if (hit_stat) begin
        rdata_r <= 32'h0000_0000;
        rdata_r[`STAT_TE_BIT] <= te_r;
        rdata_r[`STAT_RF_BIT] <= rf_r;
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  // Bus outputs straight from their registers
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  // ****************************************************************
  // Control registers
  // ****************************************************************

  // Baud rate control; reset clears LIN and divider fields
  // Reserved bit 3 is masked so it always reads zero
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      baud_rate_control_r <= `BAUD_RATE_RESET;
    end else if (wr_low && hit_baud) begin
      baud_rate_control_r <= wb_dat_i[7:0] & `BAUD_RATE_WMASK;
    end
  end

  // Prescaler control; reset clears ratio and insertion
  // Every bit of this register is writable
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      baud_prescaler_control_r <= `PRESCALER_RESET;
    end else if (wr_low && hit_psc) begin
      baud_prescaler_control_r <= wb_dat_i[7:0];
    end
  end

  // ****************************************************************
  // Data buffer, untouched by reset
  // ****************************************************************

  // Reads and writes reach separate halves, so a read-modify-write
  // on the data address would send the received byte back out
  // Transmit half loaded by bus write
  always_ff @(posedge clk_sys_i) begin
    if (data_wr) begin
      transmit_byte_r <= wb_dat_i[7:0];
    end
  end

  // Receive half loaded by the shift register
  always_ff @(posedge clk_sys_i) begin
    if (rx_load_i) begin
      received_byte_r <= rx_byte_i;
    end
  end

  // Transmit byte straight from its register
  assign transmit_byte_o = transmit_byte_r;

  // ****************************************************************
  // Buffer flags, set beats clear
  // ****************************************************************

  // A handover in the same cycle as the clearing access leaves the
  // flag set, so no event is lost to a racing bus access
  // Transmit empty: set on handover, cleared by data write
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      te_r <= `TE_FLAG_RESET;
    end else begin
      te_r <= tx_load_i || (te_r && !data_wr);
    end
  end

  // Receive full: set on arrival, cleared by data read
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rf_r <= `RF_FLAG_RESET;
    end else begin
      rf_r <= rx_load_i || (rf_r && !data_rd);
    end
  end

  // Flag outputs straight from their registers
  assign tx_buffer_empty_flag_o = te_r;
  assign rx_buffer_full_flag_o = rf_r;

  // ****************************************************************
  // Baud chain
  // ****************************************************************
  logic src_en;
  logic psc_en;
  logic [3:0] reg_prediv_value;
  logic [7:0] baud_divider_value;
  logic [12:0] prediv_wide;
  logic [12:0] baud_div_wide;
  logic [12:0] div_total_r;
  logic rt_en;
  logic [3:0] rt_cnt_r;
  logic rt_tick_r;
  logic bit_tick_r;

  // Whole chain runs on clk_sys_i: source select picks an enable,
  // prescaler thins it, divider thins it again, sample counter turns
  // sixteen sample ticks into one bit tick for both directions.
  // Divisor changes are not glitch free: a prescaler count above its new limit wraps through 15,
  // a divider count restarts at once, so the first bit after a change may be long or short.
  // Software changes divisors only while idle, and never enters
  // prescaler bypass while the serial module is enabled.
  // Bus clock enables every cycle, crystal by its enable
  assign src_en = baud_source_select_i ? crystal_clock_en_i : 1'b1;

  baud_prescaler u_prescaler (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .src_en_i(src_en),
    .prescale_ratio_select_i(baud_prescaler_control_r.prescale_ratio_select),
    .clock_insertion_count_i(baud_prescaler_control_r.clock_insertion_count),
    .out_en_o(psc_en)
  );

  // Register prescaler divisor lookup
  always_comb begin
    case ({baud_rate_control_r.reg_prediv_select_hi,
           baud_rate_control_r.reg_prediv_select_lo})
      2'b00: reg_prediv_value = `PREDIV_CODE0;
      2'b01: reg_prediv_value = `PREDIV_CODE1;
      2'b10: reg_prediv_value = `PREDIV_CODE2;
      default: reg_prediv_value = `PREDIV_CODE3;
    endcase
  end

  assign baud_divider_value = `BAUD_DIV_ONE << baud_rate_control_r.baud_divider_select;

  // Operands widened before the product so no bit is lost
  assign prediv_wide = {9'h000, reg_prediv_value};
  assign baud_div_wide = {5'h00, baud_divider_value};

  // Combined divisor: quarter stage, register prescaler, baud divisor
  // Largest product is 6656, within the 13-bit divider
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      div_total_r <= 13'(`RT_DIVIDE);
    end else begin
      div_total_r <= 13'(`RT_DIVIDE) * prediv_wide * baud_div_wide;
    end
  end

  pulse_divider u_divider (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .en_i(psc_en),
    .divisor_i(div_total_r),
    .tick_o(rt_en)
  );

  // Sixteen sample ticks make one bit time for both directions
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rt_cnt_r <= 4'h0;
      rt_tick_r <= 1'b0;
      bit_tick_r <= 1'b0;
    end else begin
      rt_tick_r <= rt_en;
      bit_tick_r <= rt_en && rt_cnt_r == `RT_PER_BIT_LAST;
      if (rt_en) begin
        rt_cnt_r <= rt_cnt_r + 4'h1;
      end
    end
  end

  // Tick outputs straight from their registers
  assign rt_tick_o = rt_tick_r;
  assign bit_tick_o = bit_tick_r;

  // ****************************************************************
  // Break lengths
  // ****************************************************************
  lin_mode_e lin_mode;

  // LIN enables form the mode code, transmit enable as the high bit
  assign lin_mode = lin_mode_e'({baud_rate_control_r.lin_tx_break_enable,
                                 baud_rate_control_r.lin_rx_break_enable});

  // Detect and generate lengths per LIN mode and character length
  // Normal lengths of 10 and 11 bit times are this block's own choice;
  // the receive filter only screens all-zero data, software still
  // times the real break symbol
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rx_break_bits_o <= `BRK_NORMAL_8;
      tx_break_bits_o <= `BRK_NORMAL_8;
    end else begin
      case (lin_mode)
        LIN_RX_ONLY: begin
          rx_break_bits_o <= nine_bit_char_i ? `BRK_LIN_LONG_9 : `BRK_LIN_LONG_8;
          tx_break_bits_o <= nine_bit_char_i ? `BRK_NORMAL_9 : `BRK_NORMAL_8;
        end
        LIN_TX_ONLY: begin
          rx_break_bits_o <= nine_bit_char_i ? `BRK_NORMAL_9 : `BRK_NORMAL_8;
          tx_break_bits_o <= nine_bit_char_i ? `BRK_LIN_LONG_9 : `BRK_LIN_LONG_8;
        end
        LIN_BOTH: begin
          rx_break_bits_o <= nine_bit_char_i ? `BRK_LIN_LONG_9 : `BRK_LIN_LONG_8;
          tx_break_bits_o <= nine_bit_char_i ? `BRK_LIN_SHORT_9 : `BRK_LIN_SHORT_8;
        end
        default: begin
          rx_break_bits_o <= nine_bit_char_i ? `BRK_NORMAL_9 : `BRK_NORMAL_8;
          tx_break_bits_o <= nine_bit_char_i ? `BRK_NORMAL_9 : `BRK_NORMAL_8;
        end
      endcase
    end
  end

endmodule : sci_baud_generator_lin_break

// file: design/sci_baud_pkg.sv
// Types shared by the serial baud generator and data buffer block.
// Assumes the constants header is compiled alongside.
package sci_baud_pkg;

  // Layout of the baud rate control register
  typedef struct packed {
    logic lin_tx_break_enable;
    logic lin_rx_break_enable;
    logic reg_prediv_select_hi;
    logic reg_prediv_select_lo;
    logic reserved;
    logic [2:0] baud_divider_select;
  } baud_rate_control_s;

  // Layout of the baud prescaler control register
  typedef struct packed {
    logic [2:0] prescale_ratio_select;
    logic [4:0] clock_insertion_count;
  } baud_prescaler_control_s;

  // LIN break modes
  typedef enum logic [1:0] {
    LIN_OFF = 2'b00,
    LIN_RX_ONLY = 2'b01,
    LIN_TX_ONLY = 2'b10,
    LIN_BOTH = 2'b11
  } lin_mode_e;

endpackage : sci_baud_pkg

// file: tb/sci_baud_chk.sv
// Port checks for the serial baud and data buffer block.
// Assumes binding to the top module; one clock domain.
`timescale 1ns/1ps
module sci_baud_chk (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic nine_bit_char_i,
  input wire logic tx_load_i,
  input wire logic rx_load_i,
  input wire logic [7:0] transmit_byte_o,
  input wire logic tx_buffer_empty_flag_o,
  input wire logic rx_buffer_full_flag_o,
  input wire logic bit_tick_o,
  input wire logic [3:0] tx_break_bits_o
);
  // *****
  // Decoded requests
  // *****
  logic take;
  logic wr_data;
  logic rd_data;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_data = take && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h06;
  assign rd_data = take && !wb_we_i && wb_adr_i[7:2] == 6'h06;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // *****
  // Assertions
  // *****
  a_ack_next_cycle: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_tx_byte_write: assert property (wr_data |=> transmit_byte_o == $past(wb_dat_i[7:0]))
    else $error("transmit byte not loaded");
  a_te_clear_write: assert property (wr_data && !tx_load_i |=> !tx_buffer_empty_flag_o)
    else $error("tx empty not cleared");
  a_te_set_load: assert property (tx_load_i |=> tx_buffer_empty_flag_o)
    else $error("tx empty not set");
  a_rf_set_load: assert property (rx_load_i |=> rx_buffer_full_flag_o)
    else $error("rx full not set");
  a_rf_clear_read: assert property (rd_data && !rx_load_i |=> !rx_buffer_full_flag_o)
    else $error("rx full not cleared");
  a_bit_tick_pulse: assert property (bit_tick_o |=> !bit_tick_o)
    else $error("bit tick too long");
  a_break_held: assert property (!wb_cyc_i && !$past(wb_cyc_i) && $stable(nine_bit_char_i)
    |=> $stable(tx_break_bits_o))
    else $error("break length moved without cause");
endmodule : sci_baud_chk

bind sci_baud_generator_lin_break sci_baud_chk u_chk (.clk_sys_i, .reset_n_i, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .nine_bit_char_i,
  .tx_load_i, .rx_load_i, .transmit_byte_o, .tx_buffer_empty_flag_o, .rx_buffer_full_flag_o,
  .bit_tick_o, .tx_break_bits_o);

// file: tb/sci_baud_generator_lin_break_tb.sv
// Self-checking bench for the serial baud and data buffer block.
// Assumes the checker is bound and the peer model drives the shift side.
`timescale 1ns/1ps
module sci_baud_generator_lin_break_tb
  import sci_baud_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00, rx_byte_i, transmit_byte_o;
  logic [3:0] wb_sel_i = 4'h0, rx_break_bits_o, tx_break_bits_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic baud_source_select_i = 1'b0, nine_bit_char_i = 1'b0, crystal_clock_en_i;
  logic tx_load_i, rx_load_i, tx_buffer_empty_flag_o, rx_buffer_full_flag_o;
  logic rt_tick_o, bit_tick_o;
  int errors = 0, samples_checked = 0, cycles = 0, n, rt;
  localparam logic [7:0] BRS [12] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h07, 8'h03,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] PCS [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h20, 8'hE0, 8'h30, 8'h21, 8'h01, 8'h00};
  localparam int PERS [12] = '{64, 192, 256, 832, 8192, 512, 128, 512, 160, 130, 64, 256};
  // 200 MHz clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  sci_baud_generator_lin_break u_dut (.clk_sys_i, .reset_n_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .baud_source_select_i,
    .crystal_clock_en_i, .nine_bit_char_i, .tx_load_i, .rx_load_i, .rx_byte_i,
    .transmit_byte_o, .tx_buffer_empty_flag_o, .rx_buffer_full_flag_o, .rt_tick_o,
    .bit_tick_o, .rx_break_bits_o, .tx_break_bits_o);
  sci_peer_model u_peer (.clk_sys_i, .tx_load_o(tx_load_i), .rx_load_o(rx_load_i),
    .rx_byte_o(rx_byte_i), .crystal_clock_en_o(crystal_clock_en_i));
  // *****
  // Tasks
  // *****
  task wrap_up;
    if (errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task xfer(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int k;
    @(posedge clk_sys_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 100);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k >= 100) errors++;
  endtask : xfer
  task wait_bit;
    n = 0;
    rt = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
      rt += int'(rt_tick_o === 1'b1);
    end while (bit_tick_o !== 1'b1 && n < 20000);
  endtask : wait_bit
  // Hang guard
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      errors++;
      wrap_up();
    end
  end
  // *****
  // Main sequence
  // *****
  initial begin
    repeat (16) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    xfer(1'b0, 8'h1C, 4'hF, 32'h0);
    chk("baud_rate_control", 32'h0, q);
    xfer(1'b0, 8'h20, 4'hF, 32'h0);
    chk("baud_prescaler_control", 32'h0, q);
    xfer(1'b0, 8'h24, 4'hF, 32'h0);
    chk("status", 32'h80, q);
    xfer(1'b1, 8'h1C, 4'hF, 32'hFF);
    xfer(1'b1, 8'h1C, 4'h0, 32'h00);
    xfer(1'b0, 8'h1C, 4'hF, 32'h0);
    chk("baud_rate_control", 32'hF7, q);
    xfer(1'b1, 8'h30, 4'hF, 32'hFF);
    xfer(1'b0, 8'h30, 4'hF, 32'h0);
    chk("unmapped", 32'h0, q);
    xfer(1'b1, 8'h20, 4'hF, 32'hFF);
    xfer(1'b0, 8'h20, 4'hF, 32'h0);
    chk("baud_prescaler_control", 32'hFF, q);
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        nine_bit_char_i <= k[0];
        xfer(1'b1, 8'h1C, 4'hF, {24'h0, m[1:0], 6'h00});
        repeat (2) @(posedge clk_sys_i);
        chk("rx_break_bits", (m[0] ? 13 : 10) + k, {28'h0, rx_break_bits_o});
        chk("tx_break_bits", (m == 2 ? 13 : m == 3 ? 11 : 10) + k, {28'h0, tx_break_bits_o});
      end
    end
    nine_bit_char_i <= 1'b0;
    xfer(1'b1, 8'h18, 4'hF, 32'h5A);
    chk("transmit_byte", 32'h5A, {24'h0, transmit_byte_o});
    u_peer.send_char(8'hC3);
    xfer(1'b0, 8'h24, 4'hF, 32'h0);
    chk("status", 32'h20, q);
    xfer(1'b0, 8'h18, 4'hF, 32'h0);
    chk("received_byte", 32'hC3, q);
    xfer(1'b0, 8'h24, 4'hF, 32'h0);
    chk("status", 32'h00, q);
    u_peer.take_char();
    xfer(1'b0, 8'h24, 4'hF, 32'h0);
    chk("status", 32'h80, q);
    u_peer.send_char(8'h96);
    xfer(1'b1, 8'h18, 4'hF, 32'h3C);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    xfer(1'b0, 8'h24, 4'hF, 32'h0);
    chk("status", 32'h80, q);
    chk("tx_empty_flag", 32'h1, {31'h0, tx_buffer_empty_flag_o});
    chk("rx_full_flag", 32'h0, {31'h0, rx_buffer_full_flag_o});
    xfer(1'b0, 8'h1C, 4'hF, 32'h0);
    chk("baud_rate_control", 32'h0, q);
    chk("rx_break_bits", 32'hA, {28'h0, rx_break_bits_o});
    chk("tx_break_bits", 32'hA, {28'h0, tx_break_bits_o});
    xfer(1'b0, 8'h18, 4'hF, 32'h0);
    chk("received_byte", 32'h96, q);
    chk("transmit_byte", 32'h3C, {24'h0, transmit_byte_o});
    for (int i = 0; i < 12; i++) begin
      xfer(1'b1, 8'h1C, 4'hF, {24'h0, BRS[i]});
      xfer(1'b1, 8'h20, 4'hF, {24'h0, PCS[i]});
      baud_source_select_i <= (i == 11);
      wait_bit();
      wait_bit();
      wait_bit();
      chk("bit_period", PERS[i], n);
      chk("rt_per_bit", 16, rt);
    end
    wrap_up();
  end
endmodule : sci_baud_generator_lin_break_tb

// file: tb/sci_peer_model.sv
// Model of the shift register side and the crystal oscillator.
// Assumes tasks are called by the bench right after a rising edge.
`timescale 1ns/1ps
module sci_peer_model (
  input wire logic clk_sys_i,
  output logic tx_load_o = 1'b0,
  output logic rx_load_o = 1'b0,
  output logic [7:0] rx_byte_o = 8'h00,
  output logic crystal_clock_en_o = 1'b0
);
  logic rx_req_r = 1'b0;
  logic tx_req_r = 1'b0;
  logic [7:0] rx_val_r = 8'h00;
  logic [1:0] xtal_cnt_r = 2'h0;
  // Handover pulses; idle data line shows the inverse of its last value
  always @(posedge clk_sys_i) begin
    rx_load_o <= rx_req_r;
    tx_load_o <= tx_req_r;
    rx_byte_o <= rx_req_r ? rx_val_r : ~rx_byte_o;
  end
  // Crystal enable every fourth bus clock, free running
  always @(posedge clk_sys_i) begin
    xtal_cnt_r <= xtal_cnt_r + 2'h1;
    crystal_clock_en_o <= (xtal_cnt_r == 2'h3);
  end
  task send_char(input logic [7:0] b);
    @(posedge clk_sys_i);
    rx_val_r <= b;
    rx_req_r <= 1'b1;
    @(posedge clk_sys_i);
    rx_req_r <= 1'b0;
  endtask : send_char
  task take_char;
    @(posedge clk_sys_i);
    tx_req_r <= 1'b1;
    @(posedge clk_sys_i);
    tx_req_r <= 1'b0;
  endtask : take_char
endmodule : sci_peer_model
